// >>> verilog/acc_adc_ctrl.sv
// Purpose: control logic of a 10-bit successive approximation converter
// Assumes: external comparator answers within one converter clock
// Notes: analog parts sit outside; this block drives their controls
//
// Contract
// - amplifier select routes input through x8 gain
// - overrange input gives all ones result
// - underrange input gives zero result
// - result code monotonic in input
// - converter-on starts continuous conversion
// - conversion end stores result, sets done
// - high read or status write clears done
// - channel change aborts, clears done, restarts
// - three-bit field selects inputs zero to six
// - status layout: done, fast, on, channel
// - converter-off powers down converter and amplifier
// - converter clock divides by one, two, four
// - calibration ties amplifier input to zero
// - high byte bits 9-2, low bits 1-0
// - low register holds calibration, slow, amplifier
// - wait no effect, halt disables converter
`timescale 1ns/100ps
module acc_adc_ctrl
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_read,
   output logic [7:0] bus_rdata,
   input wire logic halt_mode,
   input wire logic comparator_above,
   output logic converter_power,
   output logic amplifier_power,
   output logic amplifier_route,
   output logic calibration_zero,
   output logic [2:0] channel_mux,
   output logic sample_hold,
   output logic [9:0] trial_code
);
   typedef struct packed {
      logic done;
      logic fast;
      logic on;
      logic [2:0] chan;
      logic cal;
      logic slow;
      logic amp;
      logic [9:0] result;
      acc_pkg::acc_state_t state;
      logic [3:0] bit_idx;
      logic [9:0] trial;
      logic [7:0] rdata;
      logic pwr;
      logic amp_pwr;
      logic route;
      logic zero;
      logic [2:0] mux;
      logic hold;
      logic [9:0] code;
   } acc_state_rec_t;

   acc_state_rec_t st_reg;
   acc_state_rec_t st_next;
   acc_clk_if cif ();
   logic csr_wr;
   logic hi_rd;
   logic low_wr;
   logic ch_change;
   logic active;
   logic [9:0] probe;
   logic [9:0] kept;

   // converter clock enable; halt stops it along with the converter
   acc_clk_div i_acc_clk_div
   (
      .clk_sys(clk_sys),
      .reset(reset),
      .cif(cif)
   );

   // divider select from slow and fast
   always_comb
   begin
      if (st_reg.slow)
         cif.div_sel = acc_pkg::ACC_DIV_SLOW;
      else if (st_reg.fast)
         cif.div_sel = acc_pkg::ACC_DIV_FAST;
      else
         cif.div_sel = acc_pkg::ACC_DIV_NORMAL;
   end

   // halt disables, wait is not an input at all
   assign active = st_reg.on && !halt_mode;
   assign cif.run = active;

   // bus decode
   assign csr_wr = bus_write && (bus_addr == acc_pkg::ACC_OFS_CSR);
   assign low_wr = bus_write && (bus_addr == acc_pkg::ACC_OFS_LOW);
   assign hi_rd = bus_read && (bus_addr == acc_pkg::ACC_OFS_HIGH);
   assign ch_change = csr_wr &&
      (bus_wdata[acc_pkg::ACC_CSR_CH_LSB +: 3] != st_reg.chan);

   // trial bit and kept bit for the current step
   assign probe = st_reg.trial | (10'h200 >> st_reg.bit_idx);
   assign kept = comparator_above ? st_reg.trial : probe;

   always_comb
   begin
      st_next = st_reg;
      // read data: one cycle after the read strobe, zero elsewhere
      st_next.rdata = 8'h00;
      if (bus_read)
      begin
         case (bus_addr)
            // status layout with reserved bits zero
            acc_pkg::ACC_OFS_CSR:
               st_next.rdata = {st_reg.done, st_reg.fast, st_reg.on,
                  2'b00, st_reg.chan};
            acc_pkg::ACC_OFS_HIGH:
               st_next.rdata = st_reg.result[9:2];
            // low register, top three bits read zero
            acc_pkg::ACC_OFS_LOW:
               st_next.rdata = {3'b000, st_reg.cal, st_reg.slow,
                  st_reg.amp, st_reg.result[1:0]};
            default:
               st_next.rdata = 8'h00;
         endcase
      end
      if (csr_wr)
      begin
         st_next.fast = bus_wdata[acc_pkg::ACC_CSR_FAST_BIT];
         st_next.on = bus_wdata[acc_pkg::ACC_CSR_ON_BIT];
         st_next.chan = bus_wdata[acc_pkg::ACC_CSR_CH_LSB +: 3];
      end
      if (low_wr)
      begin
         st_next.cal = bus_wdata[acc_pkg::ACC_LOW_CAL_BIT];
         st_next.slow = bus_wdata[acc_pkg::ACC_LOW_SLOW_BIT];
         st_next.amp = bus_wdata[acc_pkg::ACC_LOW_AMP_BIT];
      end
      // clear done on high read or status write
      if (hi_rd || csr_wr)
         st_next.done = 1'b0;
      // sequencer
      st_next.hold = 1'b0;
      if (!active)
      begin
         st_next.state = acc_pkg::ACC_IDLE;
         st_next.bit_idx = 4'h0;
         st_next.trial = 10'h000;
      end
      else if (ch_change)
      begin
         // abort and restart on the new channel
         st_next.state = acc_pkg::ACC_SAMPLE;
         st_next.bit_idx = 4'h0;
         st_next.trial = 10'h000;
      end
      else if (cif.tick)
      begin
         case (st_reg.state)
            acc_pkg::ACC_IDLE:
               st_next.state = acc_pkg::ACC_SAMPLE;
            acc_pkg::ACC_SAMPLE:
            begin
               st_next.hold = 1'b1;
               st_next.state = acc_pkg::ACC_STEP;
               st_next.bit_idx = 4'h0;
               st_next.trial = 10'h000;
            end
            // one approximation step per tick, MSB first
            acc_pkg::ACC_STEP:
            begin
               st_next.trial = kept;
               if (st_reg.bit_idx == 4'(acc_pkg::ACC_RESULT_BITS - 1))
               begin
                  st_next.result = kept;
                  st_next.done = 1'b1;
                  st_next.state = acc_pkg::ACC_SAMPLE;
               end
               else
                  st_next.bit_idx = st_reg.bit_idx + 4'h1;
            end
            default:
               st_next.state = acc_pkg::ACC_IDLE;
         endcase
      end
      // saturation falls out of search: all kept or none
      st_next.pwr = active;
      st_next.amp_pwr = active;
      // amplifier route in front of converter
      st_next.route = st_next.amp;
      st_next.zero = st_next.cal;
      // codes above six select nothing real; passed as written
      st_next.mux = st_next.chan;
      // trial code registered ahead so the pin comes from a flop
      st_next.code = st_next.trial | (10'h200 >> st_next.bit_idx);
   end

   // no interrupt output; done is polled
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         st_reg <= '0;
         st_reg.state <= acc_pkg::ACC_IDLE;
      end
      else
         st_reg <= st_next;
   end

   assign bus_rdata = st_reg.rdata;
   assign converter_power = st_reg.pwr;
   assign amplifier_power = st_reg.amp_pwr;
   assign amplifier_route = st_reg.route;
   assign calibration_zero = st_reg.zero;
   assign channel_mux = st_reg.mux;
   assign sample_hold = st_reg.hold;
   assign trial_code = st_reg.code;
endmodule : acc_adc_ctrl

// >>> verilog/acc_pkg.sv
// Purpose: shared constants for the converter control block
// Assumes: byte registers on a plain address/strobe port
// Notes: offsets are the printed byte addresses
package acc_pkg;
   localparam logic [7:0] ACC_OFS_CSR = 8'h34;
   localparam logic [7:0] ACC_OFS_HIGH = 8'h35;
   localparam logic [7:0] ACC_OFS_LOW = 8'h36;
   localparam logic [7:0] ACC_CSR_RESET = 8'h00;
   localparam logic [2:0] ACC_LOW_CTL_RESET = 3'h0;
   // control/status field positions
   localparam int ACC_CSR_DONE_BIT = 7;
   localparam int ACC_CSR_FAST_BIT = 6;
   localparam int ACC_CSR_ON_BIT = 5;
   localparam int ACC_CSR_CH_LSB = 0;
   // low register field positions
   localparam int ACC_LOW_CAL_BIT = 4;
   localparam int ACC_LOW_SLOW_BIT = 3;
   localparam int ACC_LOW_AMP_BIT = 2;
   // converter clock dividers
   localparam logic [1:0] ACC_DIV_FAST = 2'h0;
   localparam logic [1:0] ACC_DIV_NORMAL = 2'h1;
   localparam logic [1:0] ACC_DIV_SLOW = 2'h3;
   localparam int ACC_RESULT_BITS = 10;
   localparam logic [2:0] ACC_CH_MAX = 3'h6;
   // approximation sequencer states
   typedef enum logic [2:0] {
      ACC_IDLE = 3'b001,
      ACC_SAMPLE = 3'b010,
      ACC_STEP = 3'b100
   } acc_state_t;
endpackage : acc_pkg

// >>> verilog/acc_clk_if.sv
// Purpose: carries the converter clock enable between modules
// Assumes: one system clock
// Notes: divider drives tick, sequencer drives div_sel and run
`timescale 1ns/100ps
interface acc_clk_if;
   logic tick;
   logic [1:0] div_sel;
   logic run;
   modport divider (input div_sel, input run, output tick);
   modport user (output div_sel, output run, input tick);
endinterface : acc_clk_if

// >>> verilog/acc_clk_div.sv
// Purpose: converter clock enable from the system clock
// Assumes: div_sel holds divide-minus-one
// Notes: tick is a one-cycle enable pulse
`timescale 1ns/100ps
module acc_clk_div
(
   input wire logic clk_sys,
   input wire logic reset,
   acc_clk_if.divider cif
);
   typedef struct packed {
      logic [1:0] cnt;
      logic tick;
   } acc_div_t;
   acc_div_t st_reg;
   acc_div_t st_next;

   // count up, restart when stopped so phase is known
   always_comb
   begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (!cif.run)
         st_next.cnt = 2'h0;
      else if (st_reg.cnt >= cif.div_sel)
      begin
         st_next.cnt = 2'h0;
         st_next.tick = 1'b1;
      end
      else
         st_next.cnt = st_reg.cnt + 2'h1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign cif.tick = st_reg.tick;
endmodule : acc_clk_div

// >>> bench/acc_adc_ctrl_props.sv
// Purpose: port timing checks on the converter control block
// Assumes: control/status at 34h, amp control and low result at 36h
// Notes: a quiet cycle after each write keeps the $past depth fixed
`timescale 1ns/100ps
module acc_adc_ctrl_props
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_read,
   input wire logic [7:0] bus_rdata,
   input wire logic halt_mode,
   input wire logic converter_power,
   input wire logic amplifier_power,
   input wire logic amplifier_route,
   input wire logic calibration_zero,
   input wire logic [2:0] channel_mux,
   input wire logic sample_hold
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // register writes, each followed by a quiet cycle
   sequence s_csr;
      bus_write && bus_addr == 8'h34 ##1 !bus_write && !halt_mode;
   endsequence
   sequence s_low;
      bus_write && bus_addr == 8'h36 ##1 !bus_write;
   endsequence
   power_follow_a: assert property (s_csr |=>
      converter_power == $past(bus_wdata[5], 2)) else $error("power bad");
   amp_power_a: assert property (amplifier_power == converter_power)
      else $error("amplifier power differs");
   chan_mux_a: assert property (s_csr |=>
      channel_mux == $past(bus_wdata[2:0], 2)) else $error("channel bad");
   amp_route_a: assert property (s_low |=>
      amplifier_route == $past(bus_wdata[2], 2)) else $error("route bad");
   cal_zero_a: assert property (s_low |=>
      calibration_zero == $past(bus_wdata[4], 2)) else $error("cal bad");
   rdata_idle_a: assert property (!$past(bus_read) |->
      bus_rdata == 8'h00) else $error("read data not idle");
   low_zero_a: assert property ($past(bus_read && bus_addr == 8'h36) |->
      bus_rdata[7:5] == 3'h0) else $error("low top bits set");
   csr_resv_a: assert property ($past(bus_read && bus_addr == 8'h34) |->
      bus_rdata[4:3] == 2'h0) else $error("reserved bits set");
   halt_off_a: assert property (halt_mode |=> !converter_power)
      else $error("powered in halt");
   hold_pulse_a: assert property (sample_hold |=> !sample_hold)
      else $error("hold pulse too long");
   idle_quiet_a: assert property (!converter_power [*3] |->
      !sample_hold) else $error("sampling while off");
endmodule : acc_adc_ctrl_props

bind acc_adc_ctrl acc_adc_ctrl_props i_acc_adc_ctrl_props
(
   .clk_sys(clk_sys),
   .reset(reset),
   .bus_addr(bus_addr),
   .bus_wdata(bus_wdata),
   .bus_write(bus_write),
   .bus_read(bus_read),
   .bus_rdata(bus_rdata),
   .halt_mode(halt_mode),
   .converter_power(converter_power),
   .amplifier_power(amplifier_power),
   .amplifier_route(amplifier_route),
   .calibration_zero(calibration_zero),
   .channel_mux(channel_mux),
   .sample_hold(sample_hold)
);

// >>> bench/acc_adc_ctrl_tb_top.sv
// Purpose: register level test of the converter control block
// Assumes: comparator modelled from trial_code, gain and calibration
// Notes: a conversion is eleven converter ticks, sample plus ten steps
`timescale 1ns/100ps
module acc_adc_ctrl_tb_top;
   logic clk_sys, reset, bus_write, bus_read, halt_mode, comparator_above;
   logic converter_power, sample_hold, fast, slow;
   logic amplifier_power, amplifier_route, calibration_zero;
   logic [13:0] eff, eff_exp;
   logic [7:0] bus_addr, bus_wdata, bus_rdata, d, lw, csr;
   logic [9:0] trial_code, res;
   logic [10:0] ain;
   logic [10:0] vals [7] = '{11'h000, 11'h001, 11'h05A, 11'h155,
      11'h2A5, 11'h3FF, 11'h5AA};
   int failures, cmp_count, cyc, p, m, dv, i;

   acc_adc_ctrl i_acc_adc_ctrl
   (
      .clk_sys(clk_sys),
      .reset(reset),
      .bus_addr(bus_addr),
      .bus_wdata(bus_wdata),
      .bus_write(bus_write),
      .bus_read(bus_read),
      .bus_rdata(bus_rdata),
      .halt_mode(halt_mode),
      .comparator_above(comparator_above),
      .converter_power(converter_power),
      .amplifier_power(amplifier_power),
      .amplifier_route(amplifier_route),
      .calibration_zero(calibration_zero),
      .channel_mux(),
      .sample_hold(sample_hold),
      .trial_code(trial_code)
   );

   // ideal front end: calibration grounds it, amplifier gains eight
   assign eff = calibration_zero ? 14'h0000 :
      (amplifier_route ? {ain, 3'h0} : {3'h0, ain});
   // ideal comparator: high when input lies below the trial code
   assign comparator_above = eff < {4'h0, trial_code};

   // free running system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task close_out;
      if (failures == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   task chk(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch %0t got %h expected %h", $time, g, e);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_wdata <= v;
      bus_write <= 1'b1;
      @(posedge clk_sys);
      bus_write <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_read <= 1'b1;
      @(posedge clk_sys);
      bus_read <= 1'b0;
      #1 d = bus_rdata;
   endtask : rd

   // cycles from one sampling pulse to the next
   task per(output int n);
      n = 0;
      @(posedge sample_hold);
      do
      begin
         @(posedge clk_sys);
         #1 n++;
      end
      while (sample_hold !== 1'b1 && n < 999);
   endtask : per

   task wait_done;
      for (int k = 0; k < 200 && d[7] !== 1'b1; k++)
         rd(8'h34);
      chk(d & 8'h80, 8'h80);
   endtask : wait_done

   // no sampling pulse and no power for a while
   task quiet;
      int n;
      n = 0;
      repeat (63)
      begin
         @(posedge clk_sys);
         #1 n += int'(sample_hold !== 1'b0);
      end
      chk(8'(n), 8'h00);
      chk({7'h0, converter_power}, 8'h00);
      chk({7'h0, amplifier_power}, 8'h00);
   endtask : quiet

   // hang guard; the tests need well under a thousand cycles
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         failures++;
         close_out;
      end
   end

   initial
   begin
      reset = 1'b1;
      bus_write = 1'b0;
      bus_read = 1'b0;
      halt_mode = 1'b0;
      bus_addr = 8'h00;
      bus_wdata = 8'h00;
      ain = 11'h000;
      repeat (12) @(posedge clk_sys);
      reset <= 1'b0;
      rd(8'h34);
      chk(d, 8'h00);
      rd(8'h36);
      chk(d & 8'hFC, 8'h00);
      rd(8'h37);
      chk(d, 8'h00);
      // each channel and input level once, each clock mode at least once
      for (i = 0; i < 7; i++)
      begin
         m = i % 4;
         fast = (m == 0 || m == 3);
         slow = (m > 1);
         dv = (m == 0) ? 1 : ((m == 1) ? 2 : 4);
         ain <= vals[i];
         // expected code from gain, calibration and saturation rules
         eff_exp = (i == 5) ? 14'h0000 :
            (i[1] ? {vals[i], 3'h0} : {3'h0, vals[i]});
         res = (eff_exp > 14'h03FF) ? 10'h3FF : eff_exp[9:0];
         lw = {3'h0, i == 5, slow, i[1], 2'h0};
         csr = {1'b0, fast, 1'b1, 2'h0, 3'(i)};
         // ratios only: amplifier always runs on the slowest divider
         wr(8'h36, lw);
         wr(8'h34, csr);
         rd(8'h34);
         chk(d, csr);
         per(p);
         chk(8'(p), 8'(11 * dv));
         d = 8'h00;
         wait_done;
         // halt freezes the result while it is read; the high read clears the flag
         @(posedge clk_sys);
         halt_mode <= 1'b1;
         rd(8'h36);
         chk(d, lw | {6'h0, res[1:0]});
         rd(8'h35);
         chk(d, res[9:2]);
         rd(8'h34);
         chk(d, csr);
         @(posedge clk_sys);
         halt_mode <= 1'b0;
      end
      // reset in mid-run with the converter on
      @(posedge clk_sys);
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      rd(8'h34);
      chk(d, 8'h00);
      rd(8'h36);
      chk(d & 8'hFC, 8'h00);
      wr(8'h34, 8'h20);
      @(posedge clk_sys);
      halt_mode <= 1'b1;
      quiet;
      @(posedge clk_sys);
      halt_mode <= 1'b0;
      wr(8'h34, 8'h00);
      quiet;
      close_out;
   end
endmodule : acc_adc_ctrl_tb_top
